// [dual_stage_watchdog.v]
// Function
// - Two stages, each own timeout, action
// - No-action stage skipped without waiting
// - Reset action pulses module reset
// - NMI action pulses non-maskable interrupt
// - SMI action pulses system management interrupt
// - SCI action pulses system control interrupt
// - Delay action waits then moves on
// - Software enable gates watchdog pin
// - Interrupt request from any status bit enabled in irq_en_q
`include "wdt_consts.vh"
`default_nettype none

module dual_stage_watchdog #(
    parameter integer TICK_CYCLES = `TICK_CYCLES
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Expiry outputs to host logic, active high pulses
    output reg module_reset,
    output reg nmi,
    output reg smi,
    output reg sci,
    // Watchdog pin level and interrupt request
    output reg wdt_pin,
    output reg software_interrupt_request
);
    ////////////////////////////////////////////////////////////////////////
    // State codes
    localparam [1:0] ST_IDLE = 2'h0, ST_ONE = 2'h1, ST_TWO = 2'h2, ST_DONE = 2'h3;
    // Word index from a byte address
    function [3:0] word_idx;
        input [5:0] addr;
        begin
            word_idx = addr[5:2];
        end
    endfunction
    // Stage timeout field of a stage register
    function [`STG_TMO_W-1:0] stg_tmo;
        input [31:0] r;
        begin
            stg_tmo = r[`STG_TMO_LSB +: `STG_TMO_W];
        end
    endfunction
    // Stage action field of a stage register
    function [`ACT_W-1:0] stg_act;
        input [31:0] r;
        begin
            stg_act = r[`STG_ACT_LSB +: `ACT_W];
        end
    endfunction
    reg [`CTRL_W-1:0] ctrl_q;
    reg [31:0] stage1_q, stage2_q, w_data_q;
    reg [`ST_W-1:0] status_q, irq_en_q;
    reg [1:0] state_q;
    reg [`STG_TMO_W-1:0] left_q;
    reg [15:0] rst_cnt_q, int_cnt_q;
    reg [2:0] kind_q;
    reg aw_got_q, w_got_q;
    reg [5:0] aw_addr_q;
    reg [3:0] w_strb_q;
    wire tick;
    wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    wire [3:0] wr_idx = word_idx(aw_addr_q);
    wire wr_full = (w_strb_q == 4'hf);
    wire trigger = wr_fire && wr_full && wr_idx == `OFS_TRIGGER && w_data_q == `TRIGGER_KEY;
    wire ctrl_wr = wr_fire && wr_full && wr_idx == `OFS_CTRL;
    wire run_now = ctrl_wr ? w_data_q[`CTRL_RUN] : ctrl_q[`CTRL_RUN];
    wire restart = trigger || (ctrl_wr && w_data_q[`CTRL_RUN] && !ctrl_q[`CTRL_RUN]);
    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick, realigned on every restart
    wdt_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(restart),
        .tick(tick)
    );
    ////////////////////////////////////////////////////////////////////////
    // Write channels: address and data captured in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 6'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_got_q && !s_axi_awready;
            s_axi_wready <= !w_got_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                // Read-only or unmapped words answer with an error
                s_axi_bresp <= (wr_idx == `OFS_STATUS || wr_idx >= `OFS_STATE)
                    ? `RESP_SLVERR : `RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; partial-strobe writes are ignored for safety
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= {`CTRL_W{1'b0}};
            stage1_q <= 32'h0;
            stage2_q <= 32'h0;
            irq_en_q <= {`ST_W{1'b0}};
        end
        else if (wr_fire && wr_full)
        begin
            case (wr_idx)
                `OFS_CTRL: ctrl_q <= w_data_q[`CTRL_W-1:0];
                `OFS_STAGE1: stage1_q <= w_data_q;
                `OFS_STAGE2: stage2_q <= w_data_q;
                `OFS_IRQ_EN: irq_en_q <= w_data_q[`ST_W-1:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Stage sequencer
    always @(posedge aclk)
    begin
        if (!aresetn || !run_now)
        begin
            state_q <= ST_IDLE;
            left_q <= {`STG_TMO_W{1'b0}};
        end
        else if (restart)
        begin
            state_q <= ST_ONE;
            left_q <= stg_tmo(stage1_q);
        end
        else
        begin
            case (state_q)
                ST_ONE:
                begin
                    if (stg_act(stage1_q) == `ACT_NONE || (tick && left_q <= 1))
                    begin
                        state_q <= ST_TWO;
                        left_q <= stg_tmo(stage2_q);
                    end
                    else if (tick)
                        left_q <= left_q - 1'b1;
                end
                ST_TWO:
                begin
                    if (stg_act(stage2_q) == `ACT_NONE || (tick && left_q <= 1))
                        state_q <= ST_DONE;
                    else if (tick)
                        left_q <= left_q - 1'b1;
                end
                default: ;
            endcase
        end
    end
    // Expiry of a stage with a real action this cycle
    wire exp1 = state_q == ST_ONE && tick && left_q <= 1 && run_now && !restart
        && stg_act(stage1_q) != `ACT_NONE;
    wire exp2 = state_q == ST_TWO && tick && left_q <= 1 && run_now && !restart
        && stg_act(stage2_q) != `ACT_NONE;
    wire [2:0] exp_act = exp1 ? stg_act(stage1_q) : exp2 ? stg_act(stage2_q) : `ACT_DELAY;
    wire any_exp = exp1 || exp2;
    ////////////////////////////////////////////////////////////////////////
    // Action outputs, held for a fixed pulse length
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_cnt_q <= 16'h0;
            int_cnt_q <= 16'h0;
            kind_q <= `ACT_NONE;
            module_reset <= 1'b0;
            nmi <= 1'b0;
            smi <= 1'b0;
            sci <= 1'b0;
            wdt_pin <= 1'b0;
        end
        else
        begin
            if (any_exp && exp_act == `ACT_RESET)
                rst_cnt_q <= `RESET_PULSE;
            else if (rst_cnt_q != 16'h0)
                rst_cnt_q <= rst_cnt_q - 16'h1;
            if (any_exp && (exp_act == `ACT_NMI || exp_act == `ACT_SMI || exp_act == `ACT_SCI))
            begin
                int_cnt_q <= `INT_PULSE;
                kind_q <= exp_act;
            end
            else if (int_cnt_q != 16'h0)
                int_cnt_q <= int_cnt_q - 16'h1;
            module_reset <= rst_cnt_q != 16'h0;
            nmi <= int_cnt_q != 16'h0 && kind_q == `ACT_NMI;
            smi <= int_cnt_q != 16'h0 && kind_q == `ACT_SMI;
            sci <= int_cnt_q != 16'h0 && kind_q == `ACT_SCI;
            // pin follows expiry only when enabled; trigger cancels it
            if (!ctrl_q[`CTRL_PIN_EN] || restart || !run_now)
                wdt_pin <= 1'b0;
            else if (any_exp && exp_act != `ACT_DELAY)
                wdt_pin <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event wins over a clear in the same cycle
    wire [`ST_W-1:0] ev = {
        any_exp && exp_act == `ACT_SCI,
        any_exp && exp_act == `ACT_SMI,
        any_exp && exp_act == `ACT_NMI,
        any_exp && exp_act == `ACT_RESET,
        exp2,
        exp1
    };
    wire [`ST_W-1:0] clr = (wr_fire && wr_full && wr_idx == `OFS_IRQ_CLR)
        ? w_data_q[`ST_W-1:0] : {`ST_W{1'b0}};
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status_q <= {`ST_W{1'b0}};
            software_interrupt_request <= 1'b0;
        end
        else
        begin
            status_q <= (status_q & ~clr) | ev;
            software_interrupt_request <= |(((status_q & ~clr) | ev) & irq_en_q);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Read channel, one cycle from address to data
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (word_idx(s_axi_araddr))
                `OFS_CTRL: s_axi_rdata <= {{(32-`CTRL_W){1'b0}}, ctrl_q};
                `OFS_STAGE1: s_axi_rdata <= stage1_q;
                `OFS_STAGE2: s_axi_rdata <= stage2_q;
                `OFS_STATUS: s_axi_rdata <= {{(32-`ST_W){1'b0}}, status_q};
                `OFS_IRQ_EN: s_axi_rdata <= {{(32-`ST_W){1'b0}}, irq_en_q};
                `OFS_STATE: s_axi_rdata <= {6'h0, left_q, state_q};
                `OFS_TRIGGER, `OFS_IRQ_CLR: s_axi_rdata <= 32'h0;
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else
            s_axi_arready <= !s_axi_arready;
    end
endmodule
`default_nettype wire

// [dual_stage_watchdog_bench.sv]
`include "wdt_consts.vh"
`default_nettype none
module dual_stage_watchdog_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICKC = 5;
    logic aclk, aresetn, clr;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, seen_q;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic module_reset, nmi, smi, sci, wdt_pin, software_interrupt_request;
    logic [7:0] pulses_q;
    int bad_count, cmp_count;
    dual_stage_watchdog #(.TICK_CYCLES(TICKC)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .module_reset, .nmi, .smi, .sci, .wdt_pin, .software_interrupt_request);
    host_logic_model u_host (.aclk, .aresetn, .module_reset, .nmi, .smi, .sci, .clr,
        .seen_q, .pulses_q);
    ////////////////////////////////////////////////////////////////
    // Free-running 50 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    function automatic logic [5:0] ad(input logic [3:0] idx);
        return {idx, 2'b00};
    endfunction
    // Both channels offered together, each released once taken
    task automatic wr(input logic [3:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= ad(idx);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            aw_done = aw_done | s_axi_awready;
            w_done = w_done | s_axi_wready;
            s_axi_awvalid <= !aw_done;
            s_axi_wvalid <= !w_done;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("write response", 32'(er), 32'(s_axi_bresp));
    endtask
    task automatic rd32(input logic [5:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("read response", 32'(er), 32'(s_axi_rresp));
    endtask
    task automatic ticks(input int n);
        repeat (n * TICKC) @(posedge aclk);
    endtask
    function automatic logic [31:0] exp_status(input logic [2:0] a1, input logic [2:0] a2);
        return 32'h3 | (32'h1 << (a1 + 3'h1)) | (32'h1 << (a2 + 3'h1));
    endfunction
    // Stop, clear status, program stages, clear host record, start
    task automatic arm(input logic [2:0] a1, input int t1, input logic [2:0] a2, input int t2,
        input logic [31:0] c);
        wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
        wr(`OFS_IRQ_CLR, 32'h3f, `RESP_OKAY);
        wr(`OFS_STAGE1, {t1[23:0], 5'h00, a1}, `RESP_OKAY);
        wr(`OFS_STAGE2, {t2[23:0], 5'h00, a2}, `RESP_OKAY);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        wr(`OFS_CTRL, c, `RESP_OKAY);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Hang guard, well beyond the few thousand cycles the tests need
    initial
    begin
        #1ms;
        bad_count++;
        $display("Error run length expected end seen timeout");
        print_verdict;
    end
    initial
    begin
        logic [2:0] a1, a2;
        int t1, t2;
        {aresetn, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        bad_count = 0;
        cmp_count = 0;
        void'($urandom(32'h674aec10));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        wr(`OFS_IRQ_EN, 32'h3f, `RESP_OKAY);
        arm(`ACT_NMI, 6, `ACT_SMI, 4, 32'h3);
        ticks(14);
        chk("host events", 4'b0110, seen_q);
        rd32(ad(`OFS_STATUS), `RESP_OKAY);
        chk("status", exp_status(`ACT_NMI, `ACT_SMI), rd);
        chk("pin", 1'b1, wdt_pin);
        chk("irq", 1'b1, software_interrupt_request);
        wr(`OFS_IRQ_EN, 32'h0, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("masked irq", 1'b0, software_interrupt_request);
        wr(`OFS_TRIGGER, `TRIGGER_KEY, `RESP_OKAY);
        chk("pin after trigger", 1'b0, wdt_pin);
        wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
        chk("pulse count", 2, pulses_q);
        wr(`OFS_IRQ_EN, 32'h3f, `RESP_OKAY);
        wr(`OFS_IRQ_CLR, 32'h3f, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("cleared irq", 1'b0, software_interrupt_request);
        wr(`OFS_STATUS, 32'h0, `RESP_SLVERR);
        rd32(6'h20, `RESP_SLVERR);
        $display("Test stages done");
        arm(`ACT_SCI, 3, `ACT_RESET, 2, 32'h3);
        repeat (6)
        begin
            ticks(1);
            wr(`OFS_TRIGGER, `TRIGGER_KEY, `RESP_OKAY);
        end
        chk("held off", 0, pulses_q);
        ticks(8);
        chk("host events", 4'b1001, seen_q);
        rd32(ad(`OFS_STATUS), `RESP_OKAY);
        chk("status", exp_status(`ACT_SCI, `ACT_RESET), rd);
        ticks(60);
        $display("Test trigger done");
        // skipped stage, delay stage, pin gate
        arm(`ACT_NONE, 40, `ACT_NMI, 3, 32'h1);
        ticks(6);
        chk("host events", 4'b0010, seen_q);
        chk("pin disabled", 1'b0, wdt_pin);
        arm(`ACT_DELAY, 4, `ACT_SCI, 2, 32'h3);
        ticks(3);
        chk("delay quiet", 0, pulses_q);
        ticks(5);
        chk("host events", 4'b1000, seen_q);
        chk("pin enabled", 1'b1, wdt_pin);
        $display("Test skip and delay done");
        repeat (6)
        begin
            a1 = 3'(1 + $urandom % 4);
            a2 = 3'(((a1 + $urandom % 3) % 4) + 1);
            t1 = $urandom % 5;
            t2 = 4 + $urandom % 3;
            arm(a1, t1, a2, t2, 32'h3);
            ticks(t1 + t2 + 4);
            rd32(ad(`OFS_STATUS), `RESP_OKAY);
            chk("status", exp_status(a1, a2), rd);
            chk("host events", (4'h1 << (a1 - 1)) | (4'h1 << (a2 - 1)), seen_q);
            chk("pulse count", 2, pulses_q);
            ticks(60);
        end
        $display("Test random done");
        print_verdict;
    end
endmodule
`default_nettype wire

// [host_logic_model.sv]
`default_nettype none
module host_logic_model
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Expiry lines from the watchdog
    input wire logic module_reset,
    input wire logic nmi,
    input wire logic smi,
    input wire logic sci,
    // Bench bookkeeping
    input wire logic clr,
    output logic [3:0] seen_q,
    output logic [7:0] pulses_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_q;
    logic [3:0] rise;
    // Host reacts on leading edges, so a long pulse is one event
    assign rise = {sci, smi, nmi, module_reset} & ~last_q;
    always_ff @(posedge aclk)
    begin
        last_q <= {sci, smi, nmi, module_reset};
        if (!aresetn || clr)
        begin
            seen_q <= 4'h0;
            pulses_q <= 8'h00;
        end
        else
        begin
            seen_q <= seen_q | rise;
            pulses_q <= pulses_q + 8'($countones(rise));
        end
    end
endmodule
`default_nettype wire

// [wdt_checker.sv]
`include "wdt_consts.vh"
`default_nettype none
module wdt_checker
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // Expiry outputs
    input wire logic module_reset,
    input wire logic nmi,
    input wire logic smi,
    input wire logic sci,
    input wire logic wdt_pin,
    input wire logic software_interrupt_request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] rst_run_q;
    logic trig_aw_q;
    logic trig_w_q;
    ////////////////////////////////////////////////////////////////
    // Length of the running reset pulse, too long to unroll
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !module_reset)
            rst_run_q <= 16'h0000;
        else
            rst_run_q <= rst_run_q + 16'h0001;
    end
    // Last write was a full-strobe trigger key
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_aw_q <= 1'b0;
            trig_w_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                trig_aw_q <= (s_axi_awaddr == 6'h0c);
            if (s_axi_wvalid && s_axi_wready)
                trig_w_q <= (s_axi_wdata == `TRIGGER_KEY) && (s_axi_wstrb == 4'hf);
        end
    end
    ////////////////////////////////////////////////////////////////
    // reset pulse length
    reset_pulse_len_a: assert property ($fell(module_reset) |-> rst_run_q == `RESET_PULSE)
        else $error("module reset pulse length wrong");
    nmi_pulse_len_a: assert property ($rose(nmi) |-> nmi [*8] ##1 nmi [*8] ##1 !nmi)
        else $error("nmi pulse length wrong");
    smi_pulse_len_a: assert property ($rose(smi) |-> smi [*8] ##1 smi [*8] ##1 !smi)
        else $error("smi pulse length wrong");
    sci_pulse_len_a: assert property ($rose(sci) |-> sci [*8] ##1 sci [*8] ##1 !sci)
        else $error("sci pulse length wrong");
    pin_needs_expiry_a: assert property ($rose(wdt_pin) |->
        ##[0:2] (module_reset || nmi || smi || sci))
        else $error("watchdog pin rose without expiry");
    one_action_a: assert property ($rose(nmi) |->
        !$rose(smi) && !$rose(sci) && !$rose(module_reset))
        else $error("two actions started together");
    trigger_drops_pin_a: assert property ($rose(s_axi_bvalid) && trig_aw_q && trig_w_q |->
        ##[0:2] !wdt_pin)
        else $error("watchdog pin held after trigger");
    quiet_after_reset_a: assert property ($rose(aresetn) |->
        !wdt_pin && !software_interrupt_request && !module_reset)
        else $error("outputs active after reset");
endmodule
bind dual_stage_watchdog wdt_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .module_reset, .nmi, .smi, .sci, .wdt_pin, .software_interrupt_request);
`default_nettype wire

// [wdt_consts.vh]
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// Register word indices; the byte address is four times the index
`define OFS_CTRL      4'h0
`define OFS_STAGE1    4'h1
`define OFS_STAGE2    4'h2
`define OFS_TRIGGER   4'h3
`define OFS_STATUS    4'h4
`define OFS_IRQ_EN    4'h5
`define OFS_IRQ_CLR   4'h6
`define OFS_STATE     4'h7

// Control register fields
`define CTRL_RUN      0
`define CTRL_PIN_EN   1
`define CTRL_W        2

// Stage action encodings
`define ACT_NONE      3'h0
`define ACT_RESET     3'h1
`define ACT_NMI       3'h2
`define ACT_SMI       3'h3
`define ACT_SCI       3'h4
`define ACT_DELAY     3'h5
`define ACT_W         3

// Stage register layout: action in [2:0], timeout in milliseconds in [31:8]
`define STG_ACT_LSB   0
`define STG_TMO_LSB   8
`define STG_TMO_W     24

// Trigger key written to the trigger register
`define TRIGGER_KEY   32'h0000_a5a5

// Status bits
`define ST_STAGE1     0
`define ST_STAGE2     1
`define ST_RESET      2
`define ST_NMI        3
`define ST_SMI        4
`define ST_SCI        5
`define ST_W          6

// Timing: one timeout tick per millisecond at 50 MHz
`define CLK_HZ        50000000
`define TICK_US       1000
`define TICK_CYCLES   (`CLK_HZ / 1000000 * `TICK_US)

// Output pulse lengths in cycles
`define RESET_PULSE   16'h0100
`define INT_PULSE     16'h0010

// AXI responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// [wdt_tick.v]
`default_nettype none

// Millisecond tick generator; restarts on clear so a stage starts on a full tick
module wdt_tick #(
    parameter integer CYCLES = 50000
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire clear,
    output reg tick
);

    reg [31:0] cnt_q;

    // Count cycles, pulse once per period
    always @(posedge aclk)
    begin
        if (!aresetn || clear)
        begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end
        else if (cnt_q == CYCLES - 1)
        begin
            cnt_q <= 32'h0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire
